// ---- bench/fbr_regs_props.sv ----
// concurrent checks on the feedback divider register bank ports
`timescale 1ns/1ps
`include "fbr_consts.svh"
module fbr_regs_props (
	input wire logic                  clock_i,
	input wire logic                  reset_i,
	input wire logic [11:0]           reg_addr_i,
	input wire logic                  reg_wr_i,
	input wire logic                  reg_rd_i,
	input wire fbr_pkg::fbr_byte_t    reg_wdata_i,
	input wire fbr_pkg::fbr_byte_t    reg_rdata_o,
	input wire logic                  reg_rvalid_o,
	input wire fbr_pkg::fbr_form_t    ratio_form_i,
	input wire logic [41:0]           fb_fixed_point_value_o,
	input wire logic [41:0]           fb_effective_value_o,
	input wire logic [8:0]            fb_integer_o,
	input wire logic [32:0]           fb_fraction_o,
	input wire logic [31:0]           fb_denominator_o,
	input wire logic [31:0]           fb_remainder_o,
	input wire fbr_pkg::fbr_byte_t    fb_truncate_position_o,
	input wire logic [5:0]            fb_valid_frac_bits_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	// a write or read strobe aimed at one byte offset
	sequence s_wr(logic [11:0] a); reg_wr_i && reg_addr_i == a; endsequence
	sequence s_rd(logic [11:0] a); reg_rd_i && reg_addr_i == a; endsequence
	read_answer_a: assert property (reg_rd_i |=> reg_rvalid_o) else $error("read not answered");
	top_unused_a: assert property (s_rd(`FBR_OFS_DIV_TOP) |=> reg_rdata_o[7:2] == 6'h00)
		else $error("unused top bits not zero");
	byte4_map_a: assert property (s_wr(`FBR_OFS_DIV_BYTE4) |-> ##2
		fb_fixed_point_value_o[39:32] == $past(reg_wdata_i, 2)) else $error("byte4 map wrong");
	top_map_a: assert property (s_wr(`FBR_OFS_DIV_TOP) |-> ##2
		fb_fixed_point_value_o[41:40] == $past(reg_wdata_i[1:0], 2)) else $error("top map wrong");
	den_low_a: assert property (s_wr(`FBR_OFS_DEN_BYTE0) |-> ##2
		fb_denominator_o[7:0] == $past(reg_wdata_i, 2)) else $error("denominator byte wrong");
	rem_high_a: assert property (s_wr(`FBR_OFS_REM_BYTE3) |-> ##2
		fb_remainder_o[31:24] == $past(reg_wdata_i, 2)) else $error("remainder byte wrong");
	int_split_a: assert property ({fb_integer_o, fb_fraction_o} == fb_effective_value_o)
		else $error("integer split wrong");
	valid_bits_a: assert property (fb_truncate_position_o <= 8'h21 |->
		fb_valid_frac_bits_o == 6'h21 - fb_truncate_position_o[5:0]) else $error("valid bits");
	fixed_pass_a: assert property (!$past(reset_i) && $past(ratio_form_i) == fbr_pkg::FBR_FORM_FIXED
		|-> fb_effective_value_o == fb_fixed_point_value_o) else $error("fixed form altered");
	trunc_mask_a: assert property (!$past(reset_i) && $past(ratio_form_i) == fbr_pkg::FBR_FORM_RATIO
		&& fb_truncate_position_o <= 8'h21 |-> fb_effective_value_o == (fb_fixed_point_value_o
		& ~((42'h1 << fb_truncate_position_o) - 42'h1))) else $error("truncation mask wrong");
endmodule : fbr_regs_props

bind fbr_regs fbr_regs_props u_props (.*);

// ---- bench/fbr_regs_tb.sv ----
// self-checking bench for the feedback divider register bank
`timescale 1ns/1ps
module fbr_regs_tb;
	logic clock_i = 1'b0;
	logic reset_i = 1'b1;
	logic [11:0] reg_addr_i = 12'h000;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	logic dl_feeds = 1'b0;
	fbr_pkg::fbr_byte_t reg_wdata_i = 8'h00;
	fbr_pkg::fbr_form_t form = fbr_pkg::FBR_FORM_RATIO;
	fbr_pkg::fbr_byte_t rdata;
	logic rvalid, hit, den_zero, pos_bad, pos_zero_bad, top_set, low_set, err;
	logic [31:0] div_low = 32'h89AB_CDEF;
	logic [41:0] fixed_v, eff_v;
	logic [31:0] den, rem;
	logic [5:0] vbits;
	int fail_count = 0;
	int n_compared = 0;
	always #10 clock_i = ~clock_i;
	fbr_regs u_dut (.clock_i(clock_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(rdata),
		.reg_rvalid_o(rvalid), .reg_hit_o(hit), .fb_divider_low_i(div_low),
		.ratio_form_i(form), .digital_loop_feeds_i(dl_feeds), .fb_fixed_point_value_o(fixed_v),
		.fb_effective_value_o(eff_v), .fb_integer_o(), .fb_fraction_o(), .fb_denominator_o(den),
		.fb_remainder_o(rem), .fb_truncate_position_o(), .fb_valid_frac_bits_o(vbits),
		.cfg_den_zero_o(den_zero), .cfg_pos_invalid_o(pos_bad), .cfg_low_bits_set_o(low_set),
		.cfg_pos_zero_mismatch_o(pos_zero_bad), .cfg_top_bits_set_o(top_set), .cfg_error_o(err));
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	// strobes rise on a falling edge and drop on the next, so each is taken once
	task automatic wr(input logic [11:0] a, input fbr_pkg::fbr_byte_t d);
		@(negedge clock_i);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(negedge clock_i);
		reg_wr_i = 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, input fbr_pkg::fbr_byte_t exp, input logic h);
		@(negedge clock_i);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(negedge clock_i);
		reg_rd_i = 1'b0;
		check({rvalid, hit, rdata}, {1'b1, h, exp});
	endtask : rd
	// derived outputs and flags trail a register write by one more edge
	task automatic settle;
		repeat (2) @(negedge clock_i);
	endtask : settle
	// after any reset every byte reads its default and no check flag is raised
	task automatic check_defaults;
		for (int i = 0; i < 11; i++) rd(12'h10A + 12'(i), (i == 2) ? 8'h01 : 8'h00, 1'b1);
		check({den, rem, vbits, err}, {32'h1, 32'h0, 6'h21, 1'b0});
	endtask : check_defaults
	task automatic finish_test;
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : finish_test
	initial begin
		repeat (4) @(negedge clock_i);
		reset_i = 1'b0;
		check_defaults();
		rd(12'h115, 8'h00, 1'b0);
		wr(12'h109, 8'hFF);
		rd(12'h109, 8'h00, 1'b0);
		wr(12'h10B, 8'hFF);
		rd(12'h10B, 8'h03, 1'b1);
		wr(12'h10A, 8'hC5);
		for (int i = 0; i < 8; i++) wr(12'h10C + i, 8'h1F + 8'h20 * i);
		settle();
		check({den, rem}, {32'h7F5F_3F1F, 32'hFFDF_BF9F});
		check(fixed_v, {2'b11, 8'hC5, 32'h89AB_CDEF});
		for (int i = 0; i < 8; i++) rd(12'h10C + i, 8'h1F + 8'h20 * i, 1'b1);
		wr(12'h114, 8'h09);
		settle();
		check({eff_v, vbits, low_set, err}, {42'h3_C589_ABCC_00, 6'h18, 2'b11});
		div_low = 32'h89AB_CC00;
		settle();
		check({eff_v, low_set, err}, {42'h3_C589_ABCC_00, 2'b00});
		div_low = 32'h89AB_CDEF;
		form = fbr_pkg::FBR_FORM_FIXED;
		settle();
		check(eff_v, 42'h3_C589_ABCD_EF);
		wr(12'h114, 8'h22);
		settle();
		check({pos_bad, vbits}, {1'b1, 6'h00});
		wr(12'h114, 8'h00);
		settle();
		check({pos_zero_bad, pos_bad}, 2'b10);
		dl_feeds = 1'b1;
		settle();
		check(top_set, 1'b1);
		wr(12'h10B, 8'h00);
		settle();
		check(top_set, 1'b0);
		for (int i = 0; i < 4; i++) wr(12'h10C + i, 8'h00);
		settle();
		check(den_zero, 1'b1);
		// a second reset in mid-run must bring every byte back to its default
		@(negedge clock_i);
		reset_i = 1'b1;
		repeat (2) @(negedge clock_i);
		reset_i = 1'b0;
		check_defaults();
		finish_test();
	end
endmodule : fbr_regs_tb

// ---- src/fbr_byte_reg.sv ----
// one byte-wide configuration register with a reset value and writable-bit mask
`timescale 1ns/1ps

module fbr_byte_reg #(
	parameter fbr_pkg::fbr_byte_t RESET_VAL = 8'h00,
	parameter fbr_pkg::fbr_byte_t WMASK     = 8'hFF
) (
	input  wire logic               clock_i,
	input  wire logic               reset_i,
	input  wire logic               wr_i,
	input  wire fbr_pkg::fbr_byte_t wdata_i,
	output fbr_pkg::fbr_byte_t      value_o
);

	fbr_pkg::fbr_byte_t next_value;

	// bits outside the mask keep their reset value, so they read back as their RESET_VAL bits
	assign next_value = (value_o & ~WMASK) | (wdata_i & WMASK);

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			value_o <= RESET_VAL;
		end else if (wr_i) begin
			value_o <= next_value;
		end
	end

endmodule : fbr_byte_reg

// ---- src/fbr_consts.svh ----
// offsets, field positions, reset values and limits of the feedback divider register bank
`ifndef FBR_CONSTS_SVH
`define FBR_CONSTS_SVH

// register address width and byte offsets
`define FBR_ADDR_W            12
`define FBR_OFS_DIV_BYTE4     12'h10A
`define FBR_OFS_DIV_TOP       12'h10B
`define FBR_OFS_DEN_BYTE0     12'h10C
`define FBR_OFS_DEN_BYTE1     12'h10D
`define FBR_OFS_DEN_BYTE2     12'h10E
`define FBR_OFS_DEN_BYTE3     12'h10F
`define FBR_OFS_REM_BYTE0     12'h110
`define FBR_OFS_REM_BYTE1     12'h111
`define FBR_OFS_REM_BYTE2     12'h112
`define FBR_OFS_REM_BYTE3     12'h113
`define FBR_OFS_TRUNC_POS     12'h114
`define FBR_NUM_REGS          11

// register index of each single byte and of each word's low byte inside the bank
`define FBR_IDX_DIV_BYTE4     4'h0
`define FBR_IDX_DIV_TOP       4'h1
`define FBR_IDX_DEN_BYTE0     4'h2
`define FBR_IDX_REM_BYTE0     4'h6
`define FBR_IDX_TRUNC_POS     4'hA

// reset values and writable bits
`define FBR_RST_ZERO          8'h00
`define FBR_RST_DEN_BYTE0     8'h01
`define FBR_WMASK_FULL        8'hFF
`define FBR_WMASK_DIV_TOP     8'h03

// fixed-point divider layout
`define FBR_DIV_W             42
`define FBR_DIV_LOW_W         32
`define FBR_INT_W             9
`define FBR_FRAC_W            33
`define FBR_WORD_W            32
`define FBR_TRUNC_MAX         8'h21

`endif

// ---- src/fbr_pkg.sv ----
// types shared by the feedback divider register bank
package fbr_pkg;

	typedef logic [7:0] fbr_byte_t;

	// how the feedback ratio is formed by the loop logic
	typedef enum logic {
		FBR_FORM_FIXED,
		FBR_FORM_RATIO
	} fbr_form_t;

endpackage : fbr_pkg

// ---- src/fbr_regs.sv ----
// feedback divider register bank: divider top bytes, denominator, remainder, truncation
// How it works
// - divider bits 39..32 live at 0x10A
// - divider bits 41..40 in bits 1..0 of 0x10B
// - denominator is four bytes, low byte first
// - remainder is four bytes, low byte first
// - position means 33 minus valid fraction bits
// - truncation applies only in ratio form
// - divider: 9 integer bits, 33 fraction bits
`timescale 1ns/1ps

`include "fbr_consts.svh"

module fbr_regs (
	input  wire logic                        clock_i,
	input  wire logic                        reset_i,
	// byte-wide processor register port
	input  wire logic [`FBR_ADDR_W-1:0]      reg_addr_i,
	input  wire logic                        reg_wr_i,
	input  wire logic                        reg_rd_i,
	input  wire fbr_pkg::fbr_byte_t          reg_wdata_i,
	output fbr_pkg::fbr_byte_t               reg_rdata_o,
	output logic                             reg_rvalid_o,
	output logic                             reg_hit_o,
	// lower divider bytes held by the neighbouring bank
	input  wire logic [`FBR_DIV_LOW_W-1:0]   fb_divider_low_i,
	// loop configuration seen by this bank
	input  wire fbr_pkg::fbr_form_t          ratio_form_i,
	input  wire logic                        digital_loop_feeds_i,
	// values consumed by the fractional-N feedback logic
	output logic [`FBR_DIV_W-1:0]            fb_fixed_point_value_o,
	output logic [`FBR_DIV_W-1:0]            fb_effective_value_o,
	output logic [`FBR_INT_W-1:0]            fb_integer_o,
	output logic [`FBR_FRAC_W-1:0]           fb_fraction_o,
	output logic [`FBR_WORD_W-1:0]           fb_denominator_o,
	output logic [`FBR_WORD_W-1:0]           fb_remainder_o,
	output fbr_pkg::fbr_byte_t               fb_truncate_position_o,
	output logic [5:0]                       fb_valid_frac_bits_o,
	// configuration checks for software misuse
	output logic                             cfg_den_zero_o,
	output logic                             cfg_pos_invalid_o,
	output logic                             cfg_pos_zero_mismatch_o,
	output logic                             cfg_low_bits_set_o,
	output logic                             cfg_top_bits_set_o,
	output logic                             cfg_error_o
);

	fbr_pkg::fbr_byte_t          reg_bytes [`FBR_NUM_REGS];
	logic [`FBR_ADDR_W-1:0]      addr_off;
	logic                        addr_hit;
	logic [3:0]                  reg_idx;
	fbr_pkg::fbr_byte_t          read_value;

	// address decode: the bank covers one contiguous run of byte offsets
	assign addr_off = reg_addr_i - `FBR_OFS_DIV_BYTE4;
	assign addr_hit = (reg_addr_i >= `FBR_OFS_DIV_BYTE4) && (reg_addr_i <= `FBR_OFS_TRUNC_POS);
	assign reg_idx  = addr_off[3:0];

	// per-offset selects
	logic                        sel_div_byte4;
	logic                        sel_div_top;
	logic                        sel_den_byte0;
	logic                        sel_den_byte1;
	logic                        sel_den_byte2;
	logic                        sel_den_byte3;
	logic                        sel_rem_byte0;
	logic                        sel_rem_byte1;
	logic                        sel_rem_byte2;
	logic                        sel_rem_byte3;
	logic                        sel_trunc_pos;
	logic [`FBR_NUM_REGS-1:0]    sel_vec;

	// one select per byte offset, so a waveform shows which register a strobe aims at
	assign sel_div_byte4 = (reg_addr_i == `FBR_OFS_DIV_BYTE4);
	assign sel_div_top   = (reg_addr_i == `FBR_OFS_DIV_TOP);
	assign sel_den_byte0 = (reg_addr_i == `FBR_OFS_DEN_BYTE0);
	assign sel_den_byte1 = (reg_addr_i == `FBR_OFS_DEN_BYTE1);
	assign sel_den_byte2 = (reg_addr_i == `FBR_OFS_DEN_BYTE2);
	assign sel_den_byte3 = (reg_addr_i == `FBR_OFS_DEN_BYTE3);
	assign sel_rem_byte0 = (reg_addr_i == `FBR_OFS_REM_BYTE0);
	assign sel_rem_byte1 = (reg_addr_i == `FBR_OFS_REM_BYTE1);
	assign sel_rem_byte2 = (reg_addr_i == `FBR_OFS_REM_BYTE2);
	assign sel_rem_byte3 = (reg_addr_i == `FBR_OFS_REM_BYTE3);
	assign sel_trunc_pos = (reg_addr_i == `FBR_OFS_TRUNC_POS);

	// bit i of the vector enables byte register i; an unmapped address selects none
	assign sel_vec = {sel_trunc_pos, sel_rem_byte3, sel_rem_byte2, sel_rem_byte1,
	                  sel_rem_byte0, sel_den_byte3, sel_den_byte2, sel_den_byte1,
	                  sel_den_byte0, sel_div_top, sel_div_byte4};

	// one byte register per offset; only the top divider byte has a narrow mask
	for (genvar i = 0; i < `FBR_NUM_REGS; i++) begin : g_byte
		localparam fbr_pkg::fbr_byte_t RST_V =
			(i == 32'(`FBR_IDX_DEN_BYTE0)) ? `FBR_RST_DEN_BYTE0 : `FBR_RST_ZERO;
		localparam fbr_pkg::fbr_byte_t MASK_V =
			(i == 32'(`FBR_IDX_DIV_TOP)) ? `FBR_WMASK_DIV_TOP : `FBR_WMASK_FULL;

		logic wr_sel;

		assign wr_sel = reg_wr_i && sel_vec[i];

		fbr_byte_reg #(
			.RESET_VAL (RST_V),
			.WMASK     (MASK_V)
		) u_byte (
			.clock_i   (clock_i),
			.reset_i   (reset_i),
			.wr_i      (wr_sel),
			.wdata_i   (reg_wdata_i),
			.value_o   (reg_bytes[i])
		);
	end

	// read selection; unmapped offsets read as zero
	assign read_value = addr_hit ? reg_bytes[reg_idx] : `FBR_RST_ZERO;

	logic [`FBR_DIV_W-1:0]   div_value;
	logic [`FBR_WORD_W-1:0]  den_value;
	logic [`FBR_WORD_W-1:0]  rem_value;
	fbr_pkg::fbr_byte_t      pos_value;

	logic [9:0]              div_owned;

	// the ten divider bits this bank owns sit above the neighbour's 32 low bits
	assign div_owned = {reg_bytes[`FBR_IDX_DIV_TOP][1:0],
	                    reg_bytes[`FBR_IDX_DIV_BYTE4]};

	// field assembly from the byte registers
	assign div_value = {div_owned, fb_divider_low_i};
	assign den_value = {reg_bytes[`FBR_IDX_DEN_BYTE0 + 4'h3],
	                    reg_bytes[`FBR_IDX_DEN_BYTE0 + 4'h2],
	                    reg_bytes[`FBR_IDX_DEN_BYTE0 + 4'h1],
	                    reg_bytes[`FBR_IDX_DEN_BYTE0]};
	assign rem_value = {reg_bytes[`FBR_IDX_REM_BYTE0 + 4'h3],
	                    reg_bytes[`FBR_IDX_REM_BYTE0 + 4'h2],
	                    reg_bytes[`FBR_IDX_REM_BYTE0 + 4'h1],
	                    reg_bytes[`FBR_IDX_REM_BYTE0]};
	assign pos_value = reg_bytes[`FBR_IDX_TRUNC_POS];

	logic                    pos_in_range;
	logic [5:0]              pos_clamped;
	logic [5:0]              valid_bits;
	logic [`FBR_FRAC_W:0]    drop_ones;
	logic [`FBR_FRAC_W-1:0]  keep_mask;
	logic [`FBR_DIV_W-1:0]   trunc_value;
	logic                    use_ratio;

	// truncation: position counts the dropped low fraction bits
	// an out-of-range position is clamped so the mask stays defined, never wraps
	assign pos_in_range = (pos_value <= `FBR_TRUNC_MAX);
	assign pos_clamped  = pos_in_range ? pos_value[5:0] : 6'(`FBR_TRUNC_MAX);
	assign valid_bits   = 6'h21 - pos_clamped;
	assign drop_ones    = (34'h1 << pos_clamped) - 34'h1;
	assign keep_mask    = ~drop_ones[`FBR_FRAC_W-1:0];

	// integer bits pass untouched; only the fraction is masked
	assign trunc_value = {div_value[`FBR_DIV_W-1:`FBR_FRAC_W],
	                      div_value[`FBR_FRAC_W-1:0] & keep_mask};

	// fixed form ignores the position in the effective value; the position checks still use it
	assign use_ratio = (ratio_form_i == fbr_pkg::FBR_FORM_RATIO);

	logic [`FBR_DIV_W-1:0]   next_effective;

	assign next_effective = use_ratio ? trunc_value : div_value;

	logic [`FBR_INT_W-1:0]   next_integer;
	logic [`FBR_FRAC_W-1:0]  next_fraction;

	// integer and fraction halves of the value the loop will use
	assign next_integer  = next_effective[`FBR_DIV_W-1:`FBR_FRAC_W];
	assign next_fraction = next_effective[`FBR_FRAC_W-1:0];

	logic                    den_is_one;
	logic                    rem_is_zero;
	logic                    pos_is_zero;
	logic [`FBR_FRAC_W-1:0]  dropped_bits;
	logic [1:0]              top_bits;

	// building blocks of the misuse checks, kept apart so each flag reads as one line
	assign den_is_one   = (den_value == 32'h0000_0001);
	assign rem_is_zero  = (rem_value == 32'h0000_0000);
	assign pos_is_zero  = (pos_value == `FBR_RST_ZERO);
	assign dropped_bits = div_value[`FBR_FRAC_W-1:0] & ~keep_mask;
	assign top_bits     = div_value[`FBR_DIV_W-1:`FBR_DIV_W-2];

	logic  chk_den_zero;
	logic  chk_pos_invalid;
	logic  chk_pos_zero;
	logic  chk_low_bits;
	logic  chk_top_bits;
	logic  chk_any;

	// misuse checks; the hardware keeps running, these only flag the problem
	assign chk_den_zero    = (den_value == 32'h0000_0000);
	assign chk_pos_invalid = !pos_in_range;
	assign chk_pos_zero    = pos_is_zero && !(rem_is_zero && den_is_one);
	assign chk_low_bits    = use_ratio && (dropped_bits != 33'h0);
	assign chk_top_bits    = digital_loop_feeds_i && (top_bits != 2'h0);

	// one summary flag so software can poll a single bit
	assign chk_any = chk_den_zero | chk_pos_invalid | chk_pos_zero |
	                 chk_low_bits | chk_top_bits;

	// register read port: data one edge after the strobe, held until the next read
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			reg_rdata_o <= `FBR_RST_ZERO;
		end else if (reg_rd_i) begin
			reg_rdata_o <= read_value;
		end
	end

	// access pulses: each stands for exactly one cycle after its strobe
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			reg_rvalid_o <= 1'b0;
			reg_hit_o    <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			reg_hit_o    <= (reg_rd_i || reg_wr_i) && addr_hit;
		end
	end

	// raw divider toward the loop, registered so the loop sees clean edges
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			fb_fixed_point_value_o <= '0;
		end else begin
			fb_fixed_point_value_o <= div_value;
		end
	end

	// effective value and its halves; all three move on the same edge
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			fb_effective_value_o <= '0;
			fb_integer_o         <= '0;
			fb_fraction_o        <= '0;
		end else begin
			fb_effective_value_o <= next_effective;
			fb_integer_o         <= next_integer;
			fb_fraction_o        <= next_fraction;
		end
	end

	// ratio terms toward the loop; reset denominator is one, never zero
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			fb_denominator_o <= 32'h0000_0001;
			fb_remainder_o   <= 32'h0000_0000;
		end else begin
			fb_denominator_o <= den_value;
			fb_remainder_o   <= rem_value;
		end
	end

	// position and the valid-bit count derived from it
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			fb_truncate_position_o <= `FBR_RST_ZERO;
			fb_valid_frac_bits_o   <= 6'(`FBR_TRUNC_MAX);
		end else begin
			fb_truncate_position_o <= pos_value;
			fb_valid_frac_bits_o   <= valid_bits;
		end
	end

	// value checks follow the registers with one edge of delay
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			cfg_den_zero_o    <= 1'b0;
			cfg_pos_invalid_o <= 1'b0;
		end else begin
			cfg_den_zero_o    <= chk_den_zero;
			cfg_pos_invalid_o <= chk_pos_invalid;
		end
	end

	// consistency checks between fields and the loop inputs
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			cfg_pos_zero_mismatch_o <= 1'b0;
			cfg_low_bits_set_o      <= 1'b0;
			cfg_top_bits_set_o      <= 1'b0;
		end else begin
			cfg_pos_zero_mismatch_o <= chk_pos_zero;
			cfg_low_bits_set_o      <= chk_low_bits;
			cfg_top_bits_set_o      <= chk_top_bits;
		end
	end

	// summary flag lands on the same edge as the individual flags
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			cfg_error_o <= 1'b0;
		end else begin
			cfg_error_o <= chk_any;
		end
	end

endmodule : fbr_regs
